// *** hdl/blit_pkg.sv ***
// Constants, field layouts and carrier types for the queued blit parameter bank.
// Assumes a 32-bit APB host bus and a byte-wide display-memory data path.
package blit_pkg;
  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_PIXEL_DEPTH = 8'h8E;
  localparam logic [7:0] IDX_DIRECTION = 8'h8F;
  localparam logic [7:0] IDX_X_COUNT = 8'h98;
  localparam logic [7:0] IDX_Y_COUNT = 8'h9A;
  localparam logic [7:0] IDX_ROUTING = 8'h9C;
  localparam logic [7:0] IDX_BG_ROP = 8'h9E;
  localparam logic [7:0] IDX_FG_ROP = 8'h9F;
  localparam logic [7:0] IDX_DEST_ADDR = 8'hA0;
  localparam logic [7:0] IDX_MIX_ADDR = 8'hA4;
  localparam logic [7:0] IDX_MIX_STRIDE = 8'hA8;
  localparam logic [7:0] IDX_ERROR_INIT = 8'hAA;
  localparam logic [7:0] IDX_MINOR = 8'hAC;
  localparam logic [7:0] IDX_MAJOR = 8'hAE;
  localparam logic [7:0] IDX_CONTROL = 8'hB0;
  localparam logic [7:0] IDX_STATUS = 8'hB1;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ROUTE_INVAL_DIS_BIT = 7;
  localparam int ROUTE_RESULT_BIT = 6;
  localparam int ROUTE_XP_BIT = 4;
  localparam int ROUTE_MIXEN_BIT = 3;
  localparam int DIR_OPCODE_BIT = 7;
  localparam int DIR_ERROR_LOAD_FROM_QUEUE_BIT = 5;
  localparam int DEPTH_LSB = 4;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_LSB = 16;
  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] CPU_UNUSED = 2'h0;
  localparam logic [1:0] CPU_SOURCE = 2'h1;
  localparam logic [1:0] CPU_MIX = 2'h2;
  localparam logic [1:0] DEPTH_3BYTE = 2'h2;
  localparam logic [7:0] ROP_NOOP = 8'hAA;
  localparam logic [2:0] BLIT_STEP_4 = 3'h4;
  localparam logic [2:0] BLIT_STEP_3 = 3'h3;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } eng_state_t;
  // Queued parameter set, captured as one unit at start
  typedef struct packed {
    logic [1:0] pixel_depth;
    logic graphics_opcode;
    logic error_load_from_queue;
    logic [11:0] x_count;
    logic [11:0] y_count;
    logic cache_keep;
    logic result_route_select;
    logic transparency_enable;
    logic mix_map_enable;
    logic [1:0] cpu_data_route;
    logic [7:0] background_rop;
    logic [7:0] foreground_rop;
    logic [21:0] dest_addr;
    logic [24:0] mix_addr;
    logic [11:0] mix_stride;
    logic [15:0] error_term;
    logic [11:0] minor_delta;
    logic [11:0] major_delta;
  } blit_params_t;
  // Per-byte operands fed in by the memory side
  typedef struct packed {
    logic [7:0] src;
    logic [7:0] pat;
    logic [7:0] dst;
    logic [7:0] cpu;
    logic cpu_mix;
    logic mem_mix;
  } byte_in_t;
endpackage

// *** hdl/mix_route_decode.sv ***
// Decodes CPU routing and mix-map enable into mix source selection.
// Assumes purely combinational use inside the engine's per-byte cycle.
`timescale 1ns/100ps
module mix_route_decode
  import blit_pkg::*;
(
  input wire logic [1:0] cpu_data_route_i, // Routing code
  input wire logic mix_map_enable_i, // Mix map participates
  input wire logic cpu_mix_i, // Mix bit from CPU data
  input wire logic mem_mix_i, // Mix bit from display memory
  output logic mix_bit_o, // Chosen mix bit
  output logic mem_fetch_o, // Fetch mix from memory
  output logic src_from_cpu_o // CPU byte is source
);
  // Reserved code falls through as unused, so nothing else is disturbed
  always_comb begin
    mix_bit_o = 1'b1;
    mem_fetch_o = 1'b0;
    src_from_cpu_o = 1'b0;
    case (cpu_data_route_i)
      CPU_SOURCE: src_from_cpu_o = 1'b1;
      CPU_MIX: mix_bit_o = cpu_mix_i;
      default: src_from_cpu_o = 1'b0;
    endcase
    if (cpu_data_route_i != CPU_MIX && mix_map_enable_i) begin
      mem_fetch_o = 1'b1;
      mix_bit_o = mem_mix_i;
    end
  end
endmodule

// *** hdl/rop_byte_unit.sv ***
// Applies background or foreground raster operation to one byte.
// Assumes operands are stable during the cycle; fully combinational.
`timescale 1ns/100ps
module rop_byte_unit
  import blit_pkg::*;
(
  input wire logic [7:0] src_i, // Source byte
  input wire logic [7:0] pat_i, // Pattern byte
  input wire logic [7:0] dst_i, // Destination byte
  input wire logic [7:0] bg_rop_i, // Background operation
  input wire logic [7:0] fg_rop_i, // Foreground operation
  input wire logic mix_i, // Mix bit for this byte
  input wire logic xp_en_i, // Transparency enable
  output logic [7:0] result_o, // Combined byte
  output logic byte_we_o, // Destination byte may change
  output logic dst_needed_o // Destination must be read
);
  logic [7:0] rop;
  logic fg_no_dst;
  logic xp_active;
  // Each result bit indexes the code with pattern, source, destination
  always_comb begin
    rop = mix_i ? fg_rop_i : bg_rop_i;
    for (int i = 0; i < 8; i++) begin
      result_o[i] = rop[{pat_i[i], src_i[i], dst_i[i]}];
    end
  end
  // Foreground ignores destination when odd and even code bits pair up
  always_comb begin
    fg_no_dst = ((fg_rop_i >> 1) & 8'h55) == (fg_rop_i & 8'h55);
    xp_active = xp_en_i && bg_rop_i == ROP_NOOP && fg_no_dst;
    byte_we_o = !(xp_active && !mix_i);
    dst_needed_o = !xp_active;
  end
endmodule

// *** hdl/blit_line_accel_params.sv ***
// Queued blit/line parameter registers with APB access and a byte engine.
// Assumes APB master per AMBA rules; memory side supplies operands each cycle.
`timescale 1ns/100ps
// Behaviour
// - Twelve-bit Y count runs count plus one lines
// - Bit 7 set keeps cache; clear invalidates
// - Bit 6 routes results to host, else memory
// - Transparency masks bytes, skips destination reads
// - Mix enable fetches mix from memory address
// - Mix disabled means mix one; CPU overrides
// - CPU route codes: unused, source, mix, reserved
// - Mix bit selects background or foreground operation
// - Mix address is a bit address
// - Line advance adds stride plus one bits
// - Line error starts from register or major
// - Block transfers ignore the error register
// - Routing register is queued, not immediate
// - Depth code gives bytes; blit step four/three
// - Opcode zero blit, one line draw
module blit_line_accel_params
  import blit_pkg::*;
(
  input wire logic core_clk_i, // System clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB access phase
  input wire logic pwrite_i, // APB write
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic [3:0] pstrb_i, // APB byte strobes
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire byte_in_t byte_i, // Operands for the current byte
  output logic [21:0] dest_addr_o, // Destination byte address
  output logic [24:0] mix_addr_o, // Mix bit address
  output logic mix_fetch_o, // Mix bit read from memory
  output logic dst_read_o, // Destination read needed
  output logic [7:0] result_o, // Result byte
  output logic mem_we_o, // Write result to display memory
  output logic host_valid_o, // Result byte for host CPU
  output logic cache_inval_o, // One-cycle cache invalidate
  output logic [2:0] step_bytes_o, // Bytes per engine step
  output logic [15:0] error_term_o, // Live line error term
  output logic busy_o // Operation in progress
);
  // ----------------------------------------------------------------------
  // Register front: APB slave
  // ----------------------------------------------------------------------
  blit_params_t shadow;
  blit_params_t active;
  logic [7:0] idx;
  logic setup;
  logic access;
  logic hit;
  logic [31:0] wmask;
  logic [31:0] next_prdata;
  logic start_req;
  eng_state_t state;

  assign idx = paddr_i[9:2];
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && pready_o;
  assign wmask = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

  // Address decode shared by read mux and error response
  always_comb begin
    hit = 1'b1;
    next_prdata = REG_RESET;
    case (idx)
      IDX_PIXEL_DEPTH: next_prdata[DEPTH_LSB +: 2] = shadow.pixel_depth;
      IDX_DIRECTION: begin
        next_prdata[DIR_OPCODE_BIT] = shadow.graphics_opcode;
        next_prdata[DIR_ERROR_LOAD_FROM_QUEUE_BIT] = shadow.error_load_from_queue;
      end
      IDX_X_COUNT: next_prdata[11:0] = shadow.x_count;
      IDX_Y_COUNT: next_prdata[11:0] = shadow.y_count;
      IDX_ROUTING: begin
        next_prdata[ROUTE_INVAL_DIS_BIT] = shadow.cache_keep;
        next_prdata[ROUTE_RESULT_BIT] = shadow.result_route_select;
        next_prdata[ROUTE_XP_BIT] = shadow.transparency_enable;
        next_prdata[ROUTE_MIXEN_BIT] = shadow.mix_map_enable;
        next_prdata[1:0] = shadow.cpu_data_route;
      end
      IDX_BG_ROP: next_prdata[7:0] = shadow.background_rop;
      IDX_FG_ROP: next_prdata[7:0] = shadow.foreground_rop;
      IDX_DEST_ADDR: next_prdata[21:0] = shadow.dest_addr;
      IDX_MIX_ADDR: next_prdata[24:0] = shadow.mix_addr;
      IDX_MIX_STRIDE: next_prdata[11:0] = shadow.mix_stride;
      IDX_ERROR_INIT: next_prdata[15:0] = shadow.error_term;
      IDX_MINOR: next_prdata[11:0] = shadow.minor_delta;
      IDX_MAJOR: next_prdata[11:0] = shadow.major_delta;
      IDX_CONTROL: next_prdata = REG_RESET;
      IDX_STATUS: begin
        next_prdata[STAT_BUSY_BIT] = busy_o;
        next_prdata[STAT_ERR_LSB +: 16] = error_term_o;
      end
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait answer: ready rises in the first access cycle, registered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= REG_RESET;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !hit;
      if (setup && !pwrite_i) begin
        prdata_o <= next_prdata;
      end
    end
  end

  // Writes land in the queue stage only; the engine never sees them live
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shadow <= '0;
    end else if (access && pwrite_i) begin
      case (idx)
        IDX_PIXEL_DEPTH: if (pstrb_i[0]) shadow.pixel_depth <= pwdata_i[DEPTH_LSB +: 2];
        IDX_DIRECTION: if (pstrb_i[0]) begin
          shadow.graphics_opcode <= pwdata_i[DIR_OPCODE_BIT];
          shadow.error_load_from_queue <= pwdata_i[DIR_ERROR_LOAD_FROM_QUEUE_BIT];
        end
        IDX_X_COUNT: shadow.x_count <= (shadow.x_count & ~wmask[11:0]) | (pwdata_i[11:0] & wmask[11:0]);
        IDX_Y_COUNT: shadow.y_count <= (shadow.y_count & ~wmask[11:0]) | (pwdata_i[11:0] & wmask[11:0]);
        IDX_ROUTING: if (pstrb_i[0]) begin
          shadow.cache_keep <= pwdata_i[ROUTE_INVAL_DIS_BIT];
          shadow.result_route_select <= pwdata_i[ROUTE_RESULT_BIT];
          shadow.transparency_enable <= pwdata_i[ROUTE_XP_BIT];
          shadow.mix_map_enable <= pwdata_i[ROUTE_MIXEN_BIT];
          shadow.cpu_data_route <= pwdata_i[1:0];
        end
        IDX_BG_ROP: if (pstrb_i[0]) shadow.background_rop <= pwdata_i[7:0];
        IDX_FG_ROP: if (pstrb_i[0]) shadow.foreground_rop <= pwdata_i[7:0];
        IDX_DEST_ADDR: shadow.dest_addr <= (shadow.dest_addr & ~wmask[21:0]) | (pwdata_i[21:0] & wmask[21:0]);
        IDX_MIX_ADDR: shadow.mix_addr <= (shadow.mix_addr & ~wmask[24:0]) | (pwdata_i[24:0] & wmask[24:0]);
        IDX_MIX_STRIDE: shadow.mix_stride <= (shadow.mix_stride & ~wmask[11:0]) | (pwdata_i[11:0] & wmask[11:0]);
        IDX_ERROR_INIT: shadow.error_term <= (shadow.error_term & ~wmask[15:0]) | (pwdata_i[15:0] & wmask[15:0]);
        IDX_MINOR: shadow.minor_delta <= (shadow.minor_delta & ~wmask[11:0]) | (pwdata_i[11:0] & wmask[11:0]);
        IDX_MAJOR: shadow.major_delta <= (shadow.major_delta & ~wmask[11:0]) | (pwdata_i[11:0] & wmask[11:0]);
        default: shadow <= shadow;
      endcase
    end
  end

  // Start is refused while busy; queue writes still land in the meantime
  assign start_req = access && pwrite_i && idx == IDX_CONTROL && pstrb_i[0]
    && pwdata_i[CTRL_START_BIT] && state == ST_IDLE;

  // ----------------------------------------------------------------------
  // Engine: one byte per cycle, line by line
  // ----------------------------------------------------------------------
  logic [12:0] line_len;
  logic [12:0] byte_cnt;
  logic [11:0] line_cnt;
  logic [24:0] mix_line_base;
  logic [16:0] err_sum;
  logic last_byte;
  logic last_line;
  logic mix_bit;
  logic mem_fetch;
  logic src_cpu;
  logic [7:0] rop_out;
  logic byte_we;
  logic dst_needed;

  // Line length is count plus one pixel of bytes, per the count formula
  assign line_len = {1'b0, active.x_count} + {11'h000, active.pixel_depth} + 13'h0001;
  assign last_byte = byte_cnt == line_len - 13'h0001;
  assign last_line = line_cnt == active.y_count;
  assign err_sum = {1'b0, error_term_o} + {5'h00, active.minor_delta};

  mix_route_decode u_mix (
    .cpu_data_route_i(active.cpu_data_route),
    .mix_map_enable_i(active.mix_map_enable),
    .cpu_mix_i(byte_i.cpu_mix),
    .mem_mix_i(byte_i.mem_mix),
    .mix_bit_o(mix_bit),
    .mem_fetch_o(mem_fetch),
    .src_from_cpu_o(src_cpu)
  );

  rop_byte_unit u_rop (
    .src_i(src_cpu ? byte_i.cpu : byte_i.src),
    .pat_i(byte_i.pat),
    .dst_i(byte_i.dst),
    .bg_rop_i(active.background_rop),
    .fg_rop_i(active.foreground_rop),
    .mix_i(mix_bit),
    .xp_en_i(active.transparency_enable),
    .result_o(rop_out),
    .byte_we_o(byte_we),
    .dst_needed_o(dst_needed)
  );

  // Sequencer and queue capture
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      active <= '0;
      busy_o <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (start_req) begin
          active <= shadow;
          state <= ST_RUN;
          busy_o <= 1'b1;
        end
        ST_RUN: if (last_byte && last_line) state <= ST_DONE;
        ST_DONE: begin
          state <= ST_IDLE;
          busy_o <= 1'b0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Byte and line counters; mix pointer steps one bit per byte
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      byte_cnt <= 13'h0000;
      line_cnt <= 12'h000;
      dest_addr_o <= 22'h00_0000;
      mix_addr_o <= 25'h000_0000;
      mix_line_base <= 25'h000_0000;
    end else if (state == ST_IDLE && start_req) begin
      byte_cnt <= 13'h0000;
      line_cnt <= 12'h000;
      dest_addr_o <= shadow.dest_addr;
      mix_addr_o <= shadow.mix_addr;
      mix_line_base <= shadow.mix_addr;
    end else if (state == ST_RUN) begin
      dest_addr_o <= dest_addr_o + 22'h00_0001;
      if (last_byte) begin
        byte_cnt <= 13'h0000;
        line_cnt <= line_cnt + 12'h001;
        mix_line_base <= mix_line_base + {13'h0000, active.mix_stride} + 25'h000_0001;
        mix_addr_o <= mix_line_base + {13'h0000, active.mix_stride} + 25'h000_0001;
      end else begin
        byte_cnt <= byte_cnt + 13'h0001;
        mix_addr_o <= mix_addr_o + 25'h000_0001;
      end
    end
  end

  // Error term: seeded at line-draw start, stepped once per line
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      error_term_o <= 16'h0000;
    end else if (state == ST_IDLE && start_req) begin
      if (shadow.graphics_opcode) begin
        error_term_o <= shadow.error_load_from_queue ? shadow.error_term
          : {4'h0, shadow.major_delta};
      end else begin
        error_term_o <= 16'h0000;
      end
    end else if (state == ST_RUN && active.graphics_opcode && last_byte) begin
      if (err_sum >= {5'h00, active.major_delta}) begin
        error_term_o <= 16'(err_sum - {5'h00, active.major_delta});
      end else begin
        error_term_o <= err_sum[15:0];
      end
    end
  end

  // Result routing and per-byte strobes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      result_o <= 8'h00;
      mem_we_o <= 1'b0;
      host_valid_o <= 1'b0;
      mix_fetch_o <= 1'b0;
      dst_read_o <= 1'b0;
      cache_inval_o <= 1'b0;
      step_bytes_o <= BLIT_STEP_4;
    end else begin
      result_o <= rop_out;
      mem_we_o <= state == ST_RUN && !active.result_route_select && byte_we;
      host_valid_o <= state == ST_RUN && active.result_route_select;
      mix_fetch_o <= state == ST_RUN && mem_fetch;
      dst_read_o <= state == ST_RUN && dst_needed;
      cache_inval_o <= state == ST_DONE && !active.cache_keep;
      if (active.graphics_opcode) begin
        step_bytes_o <= {1'b0, active.pixel_depth} + 3'h1;
      end else begin
        step_bytes_o <= active.pixel_depth == DEPTH_3BYTE ? BLIT_STEP_3 : BLIT_STEP_4;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_cache_inval: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cache_inval_o |-> $past(state) == ST_DONE && !active.cache_keep)
    else $error("cache invalidate without finish or while kept");
  a_host_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(state) == ST_RUN && active.result_route_select |-> host_valid_o && !mem_we_o)
    else $error("host routed result reached memory");
  a_mix_fetch: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mix_fetch_o |-> active.mix_map_enable && active.cpu_data_route != CPU_MIX)
    else $error("mix fetch without enable or with cpu mix");
  a_stride_add: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && last_byte && !last_line |=>
      mix_addr_o == $past(mix_line_base) + {13'h0000, active.mix_stride} + 25'h000_0001)
    else $error("mix pointer line advance wrong");
  a_err_seed: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_req && shadow.graphics_opcode && !shadow.error_load_from_queue |=>
      error_term_o == {4'h0, $past(shadow.major_delta)})
    else $error("error term not seeded from major delta");
  a_blit_noerr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && !active.graphics_opcode |-> error_term_o == 16'h0000)
    else $error("blit used the error term");
  a_queue_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && $past(state) == ST_RUN |-> $stable(active))
    else $error("active parameters changed mid operation");
  a_line_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && last_byte && last_line |=> state == ST_DONE ##1 !busy_o)
    else $error("operation did not end after final line");
  a_blit_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(!active.graphics_opcode && active.pixel_depth == DEPTH_3BYTE) |->
      step_bytes_o == BLIT_STEP_3)
    else $error("blit step wrong for three byte depth");
  a_xp_mask: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && active.transparency_enable && active.background_rop == ROP_NOOP
      && ((active.foreground_rop ^ (active.foreground_rop >> 1)) & 8'h55) == 8'h00
      && !mix_bit |=> !mem_we_o && !dst_read_o)
    else $error("transparent byte written or destination read");
  a_mix_fixed: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && !active.mix_map_enable && active.cpu_data_route != CPU_MIX |-> mix_bit)
    else $error("mix bit not fixed to one without mix map");
  a_reserved_route: assert property (@(posedge core_clk_i) disable iff (rst_i)
    state == ST_RUN && active.cpu_data_route == 2'h3 |-> !src_cpu
      && mix_bit == (active.mix_map_enable ? byte_i.mem_mix : 1'b1))
    else $error("reserved cpu route not treated as unused");
  a_start_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
    start_req |=> busy_o && state == ST_RUN && active == $past(shadow))
    else $error("queued parameters not captured at start");
endmodule

// *** verif/apb_host_model.sv ***
// Host processor model: issues APB register transfers to the bank.
// Assumes one clock shared with the bank; the bench calls xfer.
`timescale 1ns/100ps
module apb_host_model (
  input wire logic core_clk_i, // Bus clock
  input wire logic [31:0] prdata_i, // Read data
  input wire logic pready_i, // Slave ready
  input wire logic pslverr_i, // Slave error
  output logic psel_o, // Select
  output logic penable_o, // Access phase
  output logic pwrite_o, // Direction
  output logic [11:0] paddr_o, // Byte address
  output logic [31:0] pwdata_o // Write data
);
  // Idle bus until the first transfer
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0000_0000;
  end
  // One transfer; held until pready is seen at an edge or 16 edges pass, then released
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    ok = 1'b0;
    rd = 32'h0000_0000;
    err = 1'b0;
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= wr;
    paddr_o <= {2'h0, idx, 2'h0}; // Index is a word number
    pwdata_o <= wd;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge core_clk_i);
      if (pready_i === 1'b1) begin
        ok = 1'b1;
        rd = prdata_i;
        err = pslverr_i;
      end
    end
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule

// *** verif/blit_line_accel_params_test.sv ***
// Self-checking bench for the queued blit parameter bank.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/100ps
module blit_line_accel_params_test;
  import blit_pkg::*;
  // ----------------------------------------------------------------------
  // Signals, instances, clock
  // ----------------------------------------------------------------------
  logic core_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err, ok;
  logic mix_fetch, dst_read, mem_we, host_valid, cache_inval, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, mj;
  logic [2:0] step;
  logic [15:0] eterm, et_first, et_any;
  logic [21:0] dsa;
  logic [24:0] mxa;
  logic [7:0] result, res_last, fgc;
  logic [31:0] rv [10];
  byte_in_t byte_in;
  int failures, check_count, n_we, n_host, n_fetch, n_dst, n_inval, seen, tail, nb, d, x, y;
  logic [7:0] ridx [10] = '{IDX_Y_COUNT, IDX_ROUTING, IDX_BG_ROP, IDX_FG_ROP, IDX_DEST_ADDR,
    IDX_MIX_ADDR, IDX_MIX_STRIDE, IDX_ERROR_INIT, IDX_MINOR, IDX_MAJOR};
  logic [31:0] rmsk [10] = '{32'hFFF, 32'hDB, 32'hFF, 32'hFF, 32'h3FFFFF, 32'h1FFFFFF,
    32'hFFF, 32'hFFFF, 32'hFFF, 32'hFFF};
  // Per operation: routing byte, direction byte, expected {we,host,fetch,inval}
  logic [7:0] route [9] = '{8'h18, 8'h10, 8'h1A, 8'h1B, 8'h41, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0] dir [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h80, 8'h00};
  logic [3:0] ex [9] = '{4'h3, 4'h9, 4'h1, 4'h3, 4'h5, 4'h8, 4'h9, 4'h9, 4'h9};
  blit_line_accel_params u_blit_line_accel_params (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .byte_i(byte_in), .dest_addr_o(dsa), .mix_addr_o(mxa), .mix_fetch_o(mix_fetch),
    .dst_read_o(dst_read), .result_o(result), .mem_we_o(mem_we), .host_valid_o(host_valid),
    .cache_inval_o(cache_inval), .step_bytes_o(step), .error_term_o(eterm), .busy_o(busy));
  apb_host_model u_apb_host_model (.core_clk_i(core_clk_i), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Every written byte has mix one, so the foreground code alone picks the operand
  function automatic logic [31:0] exp_res(logic [7:0] fg, logic [7:0] rt);
    return {24'h0, fg != 8'hCC ? byte_in.pat
      : rt[1:0] == CPU_SOURCE ? byte_in.cpu : byte_in.src};
  endfunction
  // Register access; a hung bus ends the run
  task automatic acc(logic wr, logic [7:0] idx, logic [31:0] wd);
    u_apb_host_model.xfer(wr, idx, wd, rd, err, ok);
    if (!ok) begin
      failures++;
      finish_test();
    end
  endtask
  // Start and count per-byte pulses until a few cycles after busy drops
  task automatic run_op;
    {n_we, n_host, n_fetch, n_dst, n_inval, seen, tail} = '0;
    et_any = 16'h0000;
    acc(1'b1, IDX_CONTROL, 32'h1);
    for (int i = 0; i < 4000 && tail < 4; i++) begin
      @(posedge core_clk_i);
      n_we += int'(mem_we);
      n_host += int'(host_valid);
      n_fetch += int'(mix_fetch);
      n_dst += int'(dst_read);
      n_inval += int'(cache_inval);
      if (mem_we === 1'b1 || host_valid === 1'b1) res_last = result;
      et_any |= eterm;
      if (busy === 1'b1 && seen == 0) et_first = eterm;
      if (busy === 1'b1) seen = 1;
      else if (seen == 1) tail++;
    end
    if (tail < 4) begin
      failures++;
      finish_test();
    end
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    byte_in = '0;
    void'($urandom(509));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    check("step_reset", 32'h4, {29'h0, step});
    acc(1'b0, IDX_ROUTING, 32'h0);
    check("routing_reset", REG_RESET, rd);
    for (int i = 0; i < 10; i++) begin
      v = $urandom() & rmsk[i];
      rv[i] = v;
      acc(1'b1, ridx[i], v);
      acc(1'b0, ridx[i], 32'h0);
      check("readback", v, rd);
    end
    acc(1'b1, 8'h00, 32'h5);
    check("unmapped_err", 32'h1, {31'h0, err});
    // Random extents; awkward routing cases from the table
    for (int k = 0; k < 9; k++) begin
      d = (k == 8) ? 2 : int'($urandom_range(3));
      x = int'($urandom_range(4)) * (d + 1);
      y = int'($urandom_range(2));
      nb = (x + d + 1) * (y + 1);
      v = $urandom() & 32'hFFFF;
      mj = ($urandom() & 32'hFFF) | 32'h2;
      fgc = $urandom_range(1) ? 8'hCC : 8'hF0; // Both ignore the destination
      acc(1'b1, IDX_PIXEL_DEPTH, 32'(d << 4));
      acc(1'b1, IDX_X_COUNT, 32'(x));
      acc(1'b1, IDX_Y_COUNT, 32'(y));
      acc(1'b1, IDX_ROUTING, {24'h0, route[k]});
      acc(1'b1, IDX_BG_ROP, {24'h0, ROP_NOOP});
      acc(1'b1, IDX_FG_ROP, {24'h0, fgc});
      acc(1'b1, IDX_ERROR_INIT, v);
      acc(1'b1, IDX_MAJOR, mj);
      acc(1'b1, IDX_MINOR, mj >> 1);
      acc(1'b1, IDX_DIRECTION, {24'h0, dir[k]});
      byte_in <= {$urandom(), 1'b0, k == 2}; // Memory mix high only where CPU mix wins
      run_op();
      check("writes", ex[k][3] ? 32'(nb) : 0, n_we);
      check("host", ex[k][2] ? 32'(nb) : 0, n_host);
      check("fetch", ex[k][1] ? 32'(nb) : 0, n_fetch);
      check("inval", 32'(ex[k][0]), n_inval);
      if (ex[k] > 4'h3) check("result", exp_res(fgc, route[k]), 32'(res_last));
      check("dest_end", (rv[4] + nb) & 32'h3FFFFF, 32'(dsa));
      check("mix_end", (rv[5] + (y + 1) * (rv[6] + 1)) & 32'h1FFFFFF, 32'(mxa));
      if (ex[k][3:2] == 2'b00) check("dst_read", 0, n_dst);
      if (k == 6) check("err_queue", v, {16'h0, et_first});
      if (k == 7) check("err_major", mj, {16'h0, et_first});
      if (dir[k] == 8'h00) check("err_blit", 0, {16'h0, et_any});
      if (dir[k] == 8'h00) check("step", d == 2 ? 3 : 4, {29'h0, step});
    end
    finish_test();
  end
endmodule
